// file: logic/wdo_top.sv
// Write-once option latches, watchdog and stop sequencing
`timescale 1ns/1ns
// Behaviour
// - Each option latch takes one write per reset
// - Latches at two addresses, readable any time
// - Reset clears latches, baud source defaults set
// - Voltage mode bit cleared only by power-on
// - Clock-out divide select, source, pin gate
// - Timebase gets optional divide-by-128 prescaler
// - Oscillator runs in stop when bit set
// - Serial clock from bus or oscillator
// - Watchdog timeout 8176 or 262128 ticks
// - Monitor power, reset, stop-run controls
// - Stop recovery 32 or 4096 ticks
// - Reset exit from stop uses long recovery
// - Disabled stop instruction raises illegal reset
// - Disable bit holds watchdog off
// - 6-bit counter after 12-bit prescaler, resets
// - Service write clears counter, prescaler 11..4
// - Timeout pulls pin low 32 ticks, flags cause
// - Test voltage in monitor/break disables watchdog
// - Stop clears prescaler; reset clears both
// - Service address reads reset vector low byte
// - Power-on clears prescaler after 4096 ticks
// - No watchdog ticks in stop; counts in wait
module wdo_top (
   // Clock and power-on reset
   input wire logic core_clk,
   input wire logic rstn,
   // Rate enables
   input wire logic crystal_clock_tick,
   input wire logic bus_clock_tick,
   // Register port
   input wire logic [15:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // Reset vector low byte shown at the service address
   input wire logic [7:0] reset_vector_lo,
   // System events
   input wire logic internal_rst,
   input wire logic stop_exec,
   input wire logic stop_wake,
   input wire logic monitor_mode,
   input wire logic break_state,
   input wire logic test_voltage_detect_rst,
   input wire logic test_voltage_detect_irq,
   input wire logic port_d_bit0_ddr,
   input wire logic reset_cause_clear,
   // Reset outputs
   output logic watchdog_reset,
   output logic illegal_opcode_reset,
   output logic reset_pin_out,
   output logic reset_pin_oe,
   output logic watchdog_cause,
   // Stop and oscillator status
   output logic stop_active,
   output logic oscillator_enable,
   // Clock controls to other modules
   output logic clock_out_tick,
   output logic clock_out_drive,
   output logic timebase_tick,
   output logic serial_clock_tick,
   // Low-voltage monitor controls
   output logic low_voltage_monitor_on,
   output logic low_voltage_reset_en,
   output logic low_voltage_monitor_in_stop,
   output logic low_voltage_mode_select
);
   // Block state apart from the pin stretcher and tick dividers
   typedef struct packed {
      logic [7:0] latch_a;
      logic [7:0] latch_b;
      logic a_done;
      logic b_done;
      logic mode_done;
      logic [7:0] rdata;
      logic [11:0] presc;
      logic [5:0] wdcnt;
      logic [12:0] por_cnt;
      logic por_done;
      wdo_pkg::wdo_stop_e stop_st;
      logic [12:0] rec_cnt;
      logic rec_long;
      logic cause;
      logic illegal;
      logic timeout;
   } wdo_state_s;

   wdo_state_s st_r;
   wdo_state_s st_nxt;

   logic pin_active; // Reset pin held low
   logic int_rst; // Any internal reset in force
   logic wd_off; // Watchdog held off
   logic wd_tick; // Crystal tick that reaches the watchdog
   logic presc_wrap; // Prescaler rolls over this tick
   logic [5:0] wd_top; // Counter value at which timeout fires
   logic [12:0] rec_target; // Recovery length in ticks
   logic co_src_tick; // Selected clock-out source tick
   logic [7:0] co_div; // Clock-out divide factor
   logic [7:0] tb_div; // Timebase divide factor
   logic co_tick; // Divided clock-out tick

   // Internal resets: external request, own timeout, stretched pin
   assign int_rst = internal_rst | st_r.timeout | pin_active;

   // Watchdog is off by option or by test voltage in special modes
   assign wd_off = st_r.latch_a[wdo_pkg::A_WD_DIS]
      | (monitor_mode & (test_voltage_detect_rst | test_voltage_detect_irq))
      | (break_state & test_voltage_detect_rst);

   // Crystal ticks stop reaching the watchdog in stop; wait keeps them
   assign wd_tick = crystal_clock_tick & (st_r.stop_st != wdo_pkg::STP_HALT);
   assign presc_wrap = wd_tick & (st_r.presc == 12'hFFF);

   // Timeout point chosen by the rate option
   assign wd_top = st_r.latch_a[wdo_pkg::A_WD_RATE] ? wdo_pkg::WDCNT_TOP_SHORT
      : wdo_pkg::WDCNT_TOP_LONG;

   // Recovery length: short only when selected and not exiting by reset
   assign rec_target = st_r.rec_long ? wdo_pkg::REC_LONG_TICKS
      : wdo_pkg::REC_SHORT_TICKS;

   // Next state for latches, registers, watchdog and stop sequence
   always_comb begin
      st_nxt = st_r;
      st_nxt.timeout = 1'b0;
      st_nxt.illegal = 1'b0;
      st_nxt.rdata = 8'h00;

      // Read path, valid only in the cycle after the strobe
      if (reg_rd) begin
         if (reg_addr == wdo_pkg::ADDR_LATCH_A) begin
            st_nxt.rdata = st_r.latch_a;
         end else if (reg_addr == wdo_pkg::ADDR_LATCH_B) begin
            st_nxt.rdata = st_r.latch_b;
         end else if (reg_addr == wdo_pkg::ADDR_SERVICE) begin
            st_nxt.rdata = reset_vector_lo;
         end else begin
            st_nxt.rdata = 8'h00;
         end
      end

      // Option latch writes, each accepted once per reset
      if (int_rst) begin
         // Internal reset rearms latches, keeps the voltage mode bit
         st_nxt.latch_a = (st_r.latch_a & wdo_pkg::LATCH_A_POR_ONLY)
            | (wdo_pkg::LATCH_A_RST & ~wdo_pkg::LATCH_A_POR_ONLY);
         st_nxt.latch_b = wdo_pkg::LATCH_B_RST;
         st_nxt.a_done = 1'b0;
         st_nxt.b_done = 1'b0;
      end else if (reg_wr) begin
         if (reg_addr == wdo_pkg::ADDR_LATCH_A) begin
            if (!st_r.a_done) begin
               st_nxt.latch_a = (reg_wdata & ~wdo_pkg::LATCH_A_POR_ONLY)
                  | (st_r.latch_a & wdo_pkg::LATCH_A_POR_ONLY);
               st_nxt.a_done = 1'b1;
               // Voltage mode bit is writable once per power-on only
               if (!st_r.mode_done) begin
                  st_nxt.latch_a[wdo_pkg::A_LV_MODE] = reg_wdata[wdo_pkg::A_LV_MODE];
                  st_nxt.mode_done = 1'b1;
               end
            end
            // Otherwise the write is dropped
         end else if (reg_addr == wdo_pkg::ADDR_LATCH_B) begin
            if (!st_r.b_done) begin
               st_nxt.latch_b = reg_wdata;
               st_nxt.b_done = 1'b1;
            end
            // Otherwise the write is dropped
         end
      end

      // Prescaler counts crystal ticks that reach the watchdog
      if (wd_tick) begin
         st_nxt.presc = st_r.presc + 12'h001;
      end

      // Watchdog counter advances on prescaler rollover
      if (wd_off) begin
         st_nxt.wdcnt = 6'h00;
      end else if (presc_wrap) begin
         st_nxt.wdcnt = st_r.wdcnt + 6'h01;
      end

      // Timeout fires at the decoded prescaler and counter values
      if (!wd_off && !int_rst && wd_tick && st_r.presc == wdo_pkg::PRESC_FIRE
         && st_r.wdcnt == wd_top) begin
         st_nxt.timeout = 1'b1;
      end

      // Service write restarts the timeout
      if (reg_wr && reg_addr == wdo_pkg::ADDR_SERVICE) begin
         st_nxt.wdcnt = 6'h00;
         st_nxt.presc = st_r.presc & wdo_pkg::PRESC_SERVICE_KEEP;
      end

      // Power-on delay clears the prescaler once
      if (!st_r.por_done && crystal_clock_tick) begin
         if (st_r.por_cnt == wdo_pkg::POR_DELAY_TICKS - 13'h0001) begin
            st_nxt.por_done = 1'b1;
            st_nxt.presc = 12'h000;
         end else begin
            st_nxt.por_cnt = st_r.por_cnt + 13'h0001;
         end
      end

      // Stop sequencing
      case (st_r.stop_st)
         wdo_pkg::STP_RUN: begin
            if (stop_exec && !int_rst) begin
               if (st_r.latch_a[wdo_pkg::A_STOP_EN]) begin
                  st_nxt.stop_st = wdo_pkg::STP_HALT;
                  st_nxt.presc = 12'h000;
               end else begin
                  st_nxt.illegal = 1'b1;
               end
            end
         end
         wdo_pkg::STP_HALT: begin
            // A reset ends stop with the long recovery
            if (int_rst) begin
               st_nxt.stop_st = wdo_pkg::STP_RECOVER;
               st_nxt.rec_long = 1'b1;
               st_nxt.rec_cnt = 13'h0000;
            end else if (stop_wake) begin
               st_nxt.stop_st = wdo_pkg::STP_RECOVER;
               st_nxt.rec_long = ~st_r.latch_a[wdo_pkg::A_SHORT_REC];
               st_nxt.rec_cnt = 13'h0000;
            end
         end
         wdo_pkg::STP_RECOVER: begin
            // Reset during recovery forces the long delay
            if (int_rst) begin
               st_nxt.rec_long = 1'b1;
            end
            if (crystal_clock_tick) begin
               if (st_r.rec_cnt >= rec_target - 13'h0001) begin
                  st_nxt.stop_st = wdo_pkg::STP_RUN;
                  st_nxt.rec_cnt = 13'h0000;
               end else begin
                  st_nxt.rec_cnt = st_r.rec_cnt + 13'h0001;
               end
            end
         end
         default: begin
            st_nxt.stop_st = wdo_pkg::STP_RUN;
         end
      endcase

      // Any internal reset clears the prescaler and counter
      if (int_rst) begin
         st_nxt.presc = 12'h000;
         st_nxt.wdcnt = 6'h00;
      end

      // Cause flag: a new timeout wins over a clear
      if (st_r.timeout) begin
         st_nxt.cause = 1'b1;
      end else if (reset_cause_clear) begin
         st_nxt.cause = 1'b0;
      end
   end

   // State register; rstn is the power-on reset
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         st_r.latch_a <= wdo_pkg::LATCH_A_RST;
         st_r.latch_b <= wdo_pkg::LATCH_B_RST;
         st_r.a_done <= 1'b0;
         st_r.b_done <= 1'b0;
         st_r.mode_done <= 1'b0;
         st_r.rdata <= 8'h00;
         st_r.presc <= 12'h000;
         st_r.wdcnt <= 6'h00;
         st_r.por_cnt <= 13'h0000;
         st_r.por_done <= 1'b0;
         st_r.stop_st <= wdo_pkg::STP_RUN;
         st_r.rec_cnt <= 13'h0000;
         st_r.rec_long <= 1'b1;
         st_r.cause <= 1'b0;
         st_r.illegal <= 1'b0;
         st_r.timeout <= 1'b0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Reset pin stretcher started by a timeout
   wdo_pin_stretch u_stretch (
      .core_clk(core_clk),
      .rstn(rstn),
      .start(st_r.timeout),
      .tick(crystal_clock_tick),
      .active(pin_active)
   );

   // Clock-out source and divide select
   assign co_src_tick = st_r.latch_b[wdo_pkg::B_CO_SRC] ? crystal_clock_tick
      : bus_clock_tick;
   always_comb begin
      case ({st_r.latch_b[wdo_pkg::B_CO_DIV_HI], st_r.latch_b[wdo_pkg::B_CO_DIV_LO]})
         2'b01: co_div = wdo_pkg::DIV_1;
         2'b10: co_div = wdo_pkg::DIV_2;
         2'b11: co_div = wdo_pkg::DIV_4;
         default: co_div = wdo_pkg::DIV_OFF;
      endcase
   end

   // Clock-out divider
   wdo_tick_div u_co_div (
      .core_clk(core_clk),
      .rstn(rstn),
      .clr(int_rst),
      .div(co_div),
      .tick_in(co_src_tick),
      .tick_out(co_tick)
   );

   // Timebase prescaler: divide by 128 or pass through
   assign tb_div = st_r.latch_b[wdo_pkg::B_TB_PRESC] ? wdo_pkg::DIV_TB
      : wdo_pkg::DIV_1;

   wdo_tick_div u_tb_div (
      .core_clk(core_clk),
      .rstn(rstn),
      .clr(int_rst),
      .div(tb_div),
      .tick_in(crystal_clock_tick),
      .tick_out(timebase_tick)
   );

   // Clock-out pin driven only when enabled and its direction bit is set
   assign clock_out_drive = (co_div != wdo_pkg::DIV_OFF) & port_d_bit0_ddr;
   assign clock_out_tick = co_tick & clock_out_drive;

   // Serial interface clock source
   assign serial_clock_tick = st_r.latch_b[wdo_pkg::B_BAUD_SRC] ? bus_clock_tick
      : crystal_clock_tick;

   // Oscillator keeps running in stop only when the option is set
   assign stop_active = (st_r.stop_st != wdo_pkg::STP_RUN);
   assign oscillator_enable = (st_r.stop_st != wdo_pkg::STP_HALT)
      | st_r.latch_b[wdo_pkg::B_OSC_STOP];

   // Low-voltage monitor controls
   assign low_voltage_monitor_on = ~st_r.latch_a[wdo_pkg::A_LV_PWR_DIS];
   assign low_voltage_reset_en = ~st_r.latch_a[wdo_pkg::A_LV_RST_DIS];
   assign low_voltage_monitor_in_stop = st_r.latch_a[wdo_pkg::A_LV_IN_STOP]
      & ~st_r.latch_a[wdo_pkg::A_LV_PWR_DIS];
   assign low_voltage_mode_select = st_r.latch_a[wdo_pkg::A_LV_MODE];

   // Reset outputs; the pin is open drain, driven low while active
   assign watchdog_reset = st_r.timeout;
   assign illegal_opcode_reset = st_r.illegal;
   assign reset_pin_out = 1'b0;
   assign reset_pin_oe = pin_active;
   assign watchdog_cause = st_r.cause;
   assign reg_rdata = st_r.rdata;
endmodule

// file: shared/wdo_pkg.sv
// Shared constants and types for the option latches and watchdog block
package wdo_pkg;
   // Register addresses on the byte-addressed register port
   localparam logic [15:0] ADDR_LATCH_B = 16'h001E;
   localparam logic [15:0] ADDR_LATCH_A = 16'h001F;
   localparam logic [15:0] ADDR_SERVICE = 16'hFFFF;

   // Field positions in option_latch_a
   localparam int A_WD_RATE = 7;
   localparam int A_LV_IN_STOP = 6;
   localparam int A_LV_RST_DIS = 5;
   localparam int A_LV_PWR_DIS = 4;
   localparam int A_LV_MODE = 3;
   localparam int A_SHORT_REC = 2;
   localparam int A_STOP_EN = 1;
   localparam int A_WD_DIS = 0;

   // Field positions in option_latch_b
   localparam int B_CO_SRC = 7;
   localparam int B_CO_DIV_HI = 6;
   localparam int B_CO_DIV_LO = 5;
   localparam int B_TB_PRESC = 3;
   localparam int B_OSC_STOP = 1;
   localparam int B_BAUD_SRC = 0;

   // Values after reset
   localparam logic [7:0] LATCH_A_RST = 8'h00;
   localparam logic [7:0] LATCH_B_RST = 8'h01;
   // Bits of option_latch_a that only power-on reset touches
   localparam logic [7:0] LATCH_A_POR_ONLY = 8'h08;

   // Watchdog sizes and timeout decode
   localparam int PRESC_W = 12;
   localparam int WDCNT_W = 6;
   localparam logic [11:0] PRESC_FIRE = 12'hFEF;
   localparam logic [5:0] WDCNT_TOP_LONG = 6'h3F;
   localparam logic [5:0] WDCNT_TOP_SHORT = 6'h01;
   localparam logic [11:0] PRESC_SERVICE_KEEP = 12'h00F;

   // Counts in crystal clock ticks
   localparam int CNT_W = 13;
   localparam logic [12:0] POR_DELAY_TICKS = 13'h1000;
   localparam logic [12:0] REC_SHORT_TICKS = 13'h0020;
   localparam logic [12:0] REC_LONG_TICKS = 13'h1000;
   localparam logic [5:0] PIN_LOW_TICKS = 6'h20;

   // Divide factors for the tick dividers
   localparam logic [7:0] DIV_OFF = 8'h00;
   localparam logic [7:0] DIV_1 = 8'h01;
   localparam logic [7:0] DIV_2 = 8'h02;
   localparam logic [7:0] DIV_4 = 8'h04;
   localparam logic [7:0] DIV_TB = 8'h80;

   // Stop sequencing states
   typedef enum logic [1:0] {
      STP_RUN,
      STP_HALT,
      STP_RECOVER
   } wdo_stop_e;
endpackage

// file: logic/wdo_tick_div.sv
// Divides a stream of enable ticks by a run-time factor
`timescale 1ns/1ns
module wdo_tick_div (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // Control
   input wire logic clr,
   input wire logic [7:0] div,
   input wire logic tick_in,
   // Divided tick, one cycle per period
   output logic tick_out
);
   typedef struct packed {
      logic [7:0] cnt;
      logic out;
   } wdo_div_s;

   wdo_div_s st_r;
   wdo_div_s st_nxt;

   // Count input ticks and pulse on the last one of each period
   always_comb begin
      st_nxt = st_r;
      st_nxt.out = 1'b0;
      if (clr || div == wdo_pkg::DIV_OFF) begin
         st_nxt.cnt = 8'h00;
      end else if (tick_in) begin
         if (st_r.cnt >= div - 8'h01) begin
            st_nxt.cnt = 8'h00;
            st_nxt.out = 1'b1;
         end else begin
            st_nxt.cnt = st_r.cnt + 8'h01;
         end
      end
   end

   // State register
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign tick_out = st_r.out;
endmodule

// file: logic/wdo_pin_stretch.sv
// Holds the reset pin low for a fixed number of crystal ticks
`timescale 1ns/1ns
module wdo_pin_stretch (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // Start pulse and crystal tick
   input wire logic start,
   input wire logic tick,
   // High while the pin is pulled low
   output logic active
);
   typedef struct packed {
      logic [5:0] cnt;
      logic act;
   } wdo_str_s;

   wdo_str_s st_r;
   wdo_str_s st_nxt;

   // Arm on start, release after the full tick count
   always_comb begin
      st_nxt = st_r;
      if (start) begin
         st_nxt.act = 1'b1;
         st_nxt.cnt = 6'h00;
      end else if (st_r.act && tick) begin
         if (st_r.cnt == wdo_pkg::PIN_LOW_TICKS - 6'h01) begin
            st_nxt.act = 1'b0;
            st_nxt.cnt = 6'h00;
         end else begin
            st_nxt.cnt = st_r.cnt + 6'h01;
         end
      end
   end

   // State register
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign active = st_r.act;
endmodule

// file: testbench/wdo_monitor.sv
// Port checker for the option latches and watchdog block
`timescale 1ns/1ns
module wdo_monitor (
   // Clock and power-on reset
   input wire logic core_clk,
   input wire logic rstn,
   // Register port and events
   input wire logic [15:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reset_vector_lo,
   input wire logic stop_exec,
   // Block outputs
   input wire logic [7:0] reg_rdata,
   input wire logic watchdog_reset,
   input wire logic illegal_opcode_reset,
   input wire logic reset_pin_oe,
   input wire logic watchdog_cause,
   input wire logic stop_active,
   input wire logic oscillator_enable,
   input wire logic clock_out_tick,
   input wire logic clock_out_drive
);
   // One clock domain, checks idle in power-on reset
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);
   // Read data only stands in the slot after a read
   property p_rd_idle; !reg_rd |=> reg_rdata == 8'h00; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
   // Service address reads back the vector byte
   property p_svc_rd;
      reg_rd && reg_addr == wdo_pkg::ADDR_SERVICE |=> reg_rdata == $past(reset_vector_lo);
   endproperty
   a_svc_rd: assert property (p_svc_rd) else $error("service read not vector byte");
   // Timeout pulls the pin and flags the cause next cycle
   property p_pin; watchdog_reset |=> reset_pin_oe && watchdog_cause; endproperty
   a_pin: assert property (p_pin) else $error("timeout without pin or cause");
   // Timeout pulse is one cycle long
   property p_pulse; watchdog_reset |=> !watchdog_reset; endproperty
   a_pulse: assert property (p_pulse) else $error("timeout pulse too long");
   // Oscillator only stops inside stop mode
   property p_osc; !stop_active |-> oscillator_enable; endproperty
   a_osc: assert property (p_osc) else $error("oscillator off outside stop");
   // Clock-out pulses only while the pin is driven
   property p_co; clock_out_tick |-> clock_out_drive; endproperty
   a_co: assert property (p_co) else $error("clock-out pulse while not driven");
   // Illegal stop reset follows a stop request and never enters stop
   property p_ill; illegal_opcode_reset |-> $past(stop_exec) && !stop_active; endproperty
   a_ill: assert property (p_ill) else $error("illegal reset without stop request");
   // A service write keeps the timeout away for a while
   property p_svc_wr;
      reg_wr && reg_addr == wdo_pkg::ADDR_SERVICE |=> ##1 !watchdog_reset [*8];
   endproperty
   a_svc_wr: assert property (p_svc_wr) else $error("timeout right after service");
endmodule

bind wdo_top wdo_monitor i_mon (
   .core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reset_vector_lo(reset_vector_lo), .stop_exec(stop_exec), .reg_rdata(reg_rdata),
   .watchdog_reset(watchdog_reset), .illegal_opcode_reset(illegal_opcode_reset),
   .reset_pin_oe(reset_pin_oe), .watchdog_cause(watchdog_cause), .stop_active(stop_active),
   .oscillator_enable(oscillator_enable), .clock_out_tick(clock_out_tick),
   .clock_out_drive(clock_out_drive)
);

// file: testbench/wdo_fw_model.sv
// Firmware model that masters the register port
`timescale 1ns/1ns
module wdo_fw_model (
   // Clock
   input wire logic core_clk,
   // Register port, master side
   output logic [15:0] reg_addr,
   output logic [7:0] reg_wdata,
   output logic reg_wr,
   output logic reg_rd
);
   // Idle bus at time zero
   initial begin
      reg_addr = 16'h0000;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end
   // One-cycle write; released lines show inverted junk
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
   endtask
   // One-cycle read strobe
   task automatic rd(input logic [15:0] a);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      reg_addr <= ~a;
   endtask
endmodule

// file: testbench/tb.sv
// Self-checking bench for the option latches and watchdog
`timescale 1ns/1ns
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin miscompares++; \
   $display("[FAIL] t=%0t got %h exp %h", $time, a, e); end end
module tb;
   // Clock, reset and stimulus
   logic core_clk = 1'b0;
   logic rstn = 1'b0;
   logic xtal_tick = 1'b1;
   logic bus_tick = 1'b0;
   logic [15:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, vec, va;
   logic reg_wr, reg_rd, rd_p = 1'b0;
   logic int_rst = 1'b0, stop_exec = 1'b0, stop_wake = 1'b0, cclr = 1'b0;
   logic mon = 1'b0, brk = 1'b0, tvd = 1'b0, tvi = 1'b0, ddr = 1'b1;
   logic wd_rst, ill, pin_oe, cause, stp, osc, co_tick, tb_tick, lv_rst_en, lv_mode;
   logic ser, lv_on, lv_stp;
   logic [31:0] rnd, rnd_b;
   logic [7:0] exp_q[$];
   int miscompares = 0, tests_run = 0, n, m, c0, wd_cnt = 0, ill_cnt = 0;

   wdo_fw_model i_fw (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd));
   wdo_top i_dut (.core_clk(core_clk), .rstn(rstn), .crystal_clock_tick(xtal_tick),
      .bus_clock_tick(bus_tick), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reset_vector_lo(vec), .internal_rst(int_rst),
      .stop_exec(stop_exec), .stop_wake(stop_wake), .monitor_mode(mon), .break_state(brk),
      .test_voltage_detect_rst(tvd), .test_voltage_detect_irq(tvi), .port_d_bit0_ddr(ddr),
      .reset_cause_clear(cclr), .watchdog_reset(wd_rst), .illegal_opcode_reset(ill),
      .reset_pin_out(), .reset_pin_oe(pin_oe), .watchdog_cause(cause), .stop_active(stp),
      .oscillator_enable(osc), .clock_out_tick(co_tick), .clock_out_drive(),
      .timebase_tick(tb_tick), .serial_clock_tick(ser), .low_voltage_monitor_on(lv_on),
      .low_voltage_reset_en(lv_rst_en), .low_voltage_monitor_in_stop(lv_stp),
      .low_voltage_mode_select(lv_mode));

   // Clock, random bus rate and event counters
   always #10 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      rnd_b = $urandom;
      bus_tick <= rnd_b[0];
      rd_p <= reg_rd;
      if (wd_rst) wd_cnt++;
      if (ill) ill_cnt++;
   end
   // Read data against the oldest note
   always @(negedge core_clk) begin
      if (rd_p) `CHK(reg_rdata, exp_q.pop_front())
   end

   task automatic cyc(input int k);
      repeat (k) @(posedge core_clk);
      #1;
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      i_fw.rd(a);
   endtask
   // One-cycle event pulse: 0 reset, 1 stop, 2 wake, 3 cause clear
   task automatic ev(input int k);
      @(posedge core_clk);
      case (k)
         0: int_rst <= 1'b1;
         1: stop_exec <= 1'b1;
         2: stop_wake <= 1'b1;
         default: cclr <= 1'b1;
      endcase
      @(posedge core_clk);
      {int_rst, stop_exec, stop_wake, cclr} <= 4'h0;
      cyc(2);
   endtask
   task automatic end_sim;
      $display("Counts: %0d compared, %0d mismatched", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // Hang guard
   initial begin
      #1800000;
      miscompares++;
      end_sim;
   end

   initial begin
      void'($urandom(29306));
      rnd = $urandom;
      vec = rnd[15:8];
      va = (rnd[7:0] & 8'h78) | 8'h06;
      repeat (16) @(posedge core_clk);
      rstn <= 1'b1;
      rd(wdo_pkg::ADDR_LATCH_B, 8'h01);
      rd(wdo_pkg::ADDR_LATCH_A, 8'h00);
      rd(wdo_pkg::ADDR_SERVICE, vec);
      rd(16'h0020, 8'h00);
      $display("reset values done");
      // Second writes must leave the latches alone
      i_fw.wr(wdo_pkg::ADDR_LATCH_A, va);
      i_fw.wr(wdo_pkg::ADDR_LATCH_A, ~va);
      i_fw.wr(wdo_pkg::ADDR_LATCH_B, 8'hEB);
      i_fw.wr(wdo_pkg::ADDR_LATCH_B, 8'h14);
      rd(wdo_pkg::ADDR_LATCH_A, va);
      rd(wdo_pkg::ADDR_LATCH_B, 8'hEB);
      cyc(2);
      `CHK(lv_mode, va[3])
      `CHK(lv_rst_en, ~va[5])
      `CHK({lv_on, lv_stp}, {~va[4], va[6] & ~va[4]})
      $display("write once done");
      // Crystal /4 on clock-out and /128 timebase
      n = 0;
      m = 0;
      c0 = 0;
      repeat (256) begin
         cyc(1);
         n += co_tick;
         m += tb_tick;
         c0 += (ser !== bus_tick);
      end
      `CHK(n, 64)
      `CHK(c0, 0)
      `CHK(m, 2)
      $display("clock outputs done");
      // Short recovery with the oscillator kept in stop
      i_fw.wr(wdo_pkg::ADDR_SERVICE, 8'h00);
      ev(1);
      `CHK(stp, 1'b1)
      `CHK(osc, 1'b1)
      ev(2);
      n = 0;
      while (stp && n < 200) begin
         cyc(1);
         n++;
      end
      `CHK(n >= 28 && n <= 36, 1'b1)
      // Reset while halted forces the long recovery
      ev(1);
      ev(0);
      n = 0;
      while (stp && n < 5000) begin
         cyc(1);
         n++;
      end
      `CHK(n >= 4080 && n <= 4100, 1'b1)
      $display("stop recovery done");
      c0 = wd_cnt;
      cyc(9000);
      `CHK(wd_cnt, c0)
      ev(0);
      rd(wdo_pkg::ADDR_LATCH_A, va & 8'h08);
      rd(wdo_pkg::ADDR_LATCH_B, 8'h01);
      i_fw.wr(wdo_pkg::ADDR_LATCH_A, 8'h80);
      ev(1);
      `CHK(ill_cnt, 1)
      `CHK(stp, 1'b0)
      $display("internal reset done");
      // Regular service holds off the short timeout
      repeat (3) begin
         i_fw.wr(wdo_pkg::ADDR_SERVICE, 8'h5A);
         cyc(6000);
      end
      `CHK(wd_cnt, c0)
      i_fw.wr(wdo_pkg::ADDR_SERVICE, 8'h00);
      n = 0;
      while (!wd_rst && n < 9000) begin
         cyc(1);
         n++;
      end
      `CHK(n >= 8150 && n <= 8185, 1'b1)
      cyc(1);
      `CHK(cause, 1'b1)
      n = 0;
      while (pin_oe && n < 100) begin
         n++;
         cyc(1);
      end
      `CHK(n, 32)
      rd(wdo_pkg::ADDR_LATCH_A, va & 8'h08);
      ev(3);
      `CHK(cause, 1'b0)
      $display("timeout done");
      // Disable bit, then test voltage in monitor and break
      i_fw.wr(wdo_pkg::ADDR_LATCH_A, 8'h81);
      c0 = wd_cnt;
      cyc(9000);
      `CHK(wd_cnt, c0)
      ev(0);
      i_fw.wr(wdo_pkg::ADDR_LATCH_A, 8'h80);
      mon <= 1'b1;
      tvi <= 1'b1;
      cyc(9000);
      mon <= 1'b0;
      tvi <= 1'b0;
      brk <= 1'b1;
      tvd <= 1'b1;
      cyc(9000);
      `CHK(wd_cnt, c0)
      $display("watchdog off done");
      cyc(4);
      end_sim;
   end
endmodule
